// ===== src/flash_host_pkg.sv
// package: command codes, register map and bus timing for the flash host
package flash_host_pkg;
	// device command codes
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_ERASE = 8'h30;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// status bit positions on the data bus
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int LIMIT_BIT = 5;
	// host register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_STAT = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	// control register fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LSB = 1;
	// operation codes
	localparam logic [1:0] OP_PROG = 2'h0;
	localparam logic [1:0] OP_ERASE = 2'h1;
	localparam logic [1:0] OP_RESET = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	// status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_VERIFY = 3;
	// bus phase timing
	localparam int PHASE_NS = 100;
	localparam int CLK_NS = 5;
	localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUPPLY_NS = 1000;
	localparam int SUPPLY_CYC = (SUPPLY_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== src/flash_bus_cycle.sv
// one asynchronous byte-bus cycle, write or read, on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle #(
	parameter int AW = 18,
	parameter int PHASE = 20
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// request
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic o_done,
	output logic [7:0] o_rdata,
	// pins
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [AW-1:0] o_a,
	output logic [7:0] o_dq_o,
	output logic o_dq_oe,
	input wire logic [7:0] i_dq_i
);
	logic [1:0] ph_q;
	logic [7:0] cnt_q;
	logic wr_q;
	logic [7:0] s1_q;
	logic [7:0] s2_q;
	wire tick = (cnt_q == 8'(PHASE - 1));
	// data bus input synchroniser
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
		end else begin
			s1_q <= i_dq_i;
			s2_q <= s1_q;
		end
	end
	// phases: 1 setup, 2 strobe low, 3 strobe high hold
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ph_q <= 2'h0;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_ce_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_a <= '0;
			o_dq_o <= 8'h00;
			o_dq_oe <= 1'b0;
		end else begin
			o_done <= 1'b0;
			cnt_q <= (ph_q == 2'h0 || tick) ? 8'h00 : cnt_q + 8'h01;
			case (ph_q)
			2'h0: begin
				if (i_start) begin
					ph_q <= 2'h1;
					wr_q <= i_write;
					o_a <= i_addr;
					o_dq_o <= i_wdata;
					o_dq_oe <= i_write;
				end
			end
			2'h1: begin
				if (tick) begin
					// address settles before both strobes fall
					ph_q <= 2'h2;
					o_ce_n <= 1'b0;
					o_we_n <= ~wr_q;
					o_oe_n <= wr_q;
				end
			end
			2'h2: begin
				if (tick) begin
					// data held across the rising strobe edge
					ph_q <= 2'h3;
					o_we_n <= 1'b1;
					o_oe_n <= 1'b1;
					o_ce_n <= 1'b1;
					o_rdata <= s2_q;
				end
			end
			default: begin
				if (tick) begin
					ph_q <= 2'h0;
					o_dq_oe <= 1'b0;
					o_done <= 1'b1;
				end
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== src/flash_host.sv
// host controller driving program, erase and reset on a parallel flash
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
	parameter int AW = 18,
	parameter int SUPPLY_WAIT = flash_host_pkg::SUPPLY_CYC
) (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RST,
	// software register port
	input wire logic [3:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	// flash pins
	output logic O_CE_N,
	output logic O_WE_N,
	output logic O_OE_N,
	output logic [AW-1:0] O_A,
	output logic [7:0] O_DQ_O,
	output logic O_DQ_OE,
	input wire logic [7:0] I_DQ_I,
	output logic O_VPP_EN
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_RAMP = 4'h1, S_CMD1 = 4'h3, S_CMD2 = 4'h2,
		S_POLL = 4'h6, S_RECHK = 4'h7, S_VERIFY = 4'h5, S_END = 4'h4,
		S_READ = 4'hc
	} state_t;
	state_t st_q;
	logic [1:0] op_q;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] vaddr_q;
	logic [7:0] data_q;
	logic [7:0] rdata_q;
	logic busy_q, done_q, fail_q, vfail_q;
	logic [15:0] wait_q;
	logic start_q, bwr_q;
	logic [AW-1:0] baddr_q;
	logic [7:0] bdata_q;
	logic cyc_done;
	logic [7:0] cyc_rdata;
	logic [31:0] rdata_n;
	logic [7:0] code1, code2;
	logic polled_ok;
	// software decode
	wire go = I_WR && I_ADDR == flash_host_pkg::REG_CTRL
		&& I_WDATA[flash_host_pkg::CTRL_GO] && !busy_q;
	wire [1:0] go_op = I_WDATA[flash_host_pkg::CTRL_OP_LSB +: 2];
	wire [31:0] stat_w = {28'h0, vfail_q, fail_q, done_q, busy_q};
	assign rdata_n = (I_ADDR == flash_host_pkg::REG_ADDR) ? 32'(addr_q) :
		(I_ADDR == flash_host_pkg::REG_DATA) ? {24'h0, data_q} :
		(I_ADDR == flash_host_pkg::REG_STAT) ? stat_w :
		(I_ADDR == flash_host_pkg::REG_RDATA) ? {24'h0, rdata_q} : 32'h0;
	// command codes per operation
	assign code1 = (op_q == flash_host_pkg::OP_ERASE) ?
		flash_host_pkg::CMD_ERASE : (op_q == flash_host_pkg::OP_PROG) ?
		flash_host_pkg::CMD_PROG : (op_q == flash_host_pkg::OP_READ) ?
		flash_host_pkg::CMD_READ : flash_host_pkg::CMD_RESET;
	assign code2 = (op_q == flash_host_pkg::OP_PROG) ? data_q : code1;
	// erase: bit 7 reads 1 when done; program: true bit 7 returns
	assign polled_ok = (op_q == flash_host_pkg::OP_ERASE) ?
		cyc_rdata[flash_host_pkg::POLL_BIT] :
		(cyc_rdata[flash_host_pkg::POLL_BIT] ==
		data_q[flash_host_pkg::POLL_BIT]);
	// software registers
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			addr_q <= '0;
			data_q <= 8'h00;
			O_RDATA <= 32'h0;
		end else begin
			O_RDATA <= I_RD ? rdata_n : 32'h0;
			if (I_WR && I_ADDR == flash_host_pkg::REG_ADDR && !busy_q)
				addr_q <= I_WDATA[AW-1:0];
			if (I_WR && I_ADDR == flash_host_pkg::REG_DATA && !busy_q)
				data_q <= I_WDATA[7:0];
		end
	end
	// sequencer
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			st_q <= S_IDLE;
			op_q <= flash_host_pkg::OP_RESET;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			vfail_q <= 1'b0;
			wait_q <= 16'h0;
			start_q <= 1'b0;
			bwr_q <= 1'b0;
			baddr_q <= '0;
			bdata_q <= 8'h00;
			vaddr_q <= '0;
			rdata_q <= 8'h00;
			O_VPP_EN <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (I_WR && I_ADDR == flash_host_pkg::REG_STAT && !busy_q)
				done_q <= 1'b0;
			case (st_q)
			S_IDLE: begin
				if (go) begin
					op_q <= go_op;
					busy_q <= 1'b1;
					done_q <= 1'b0;
					fail_q <= 1'b0;
					vfail_q <= 1'b0;
					wait_q <= 16'h0;
					O_VPP_EN <= 1'b1;
					st_q <= S_RAMP;
				end
			end
			S_RAMP: begin
				wait_q <= wait_q + 16'h1;
				if (wait_q == 16'(SUPPLY_WAIT - 1)) begin
					start_q <= 1'b1;
					bwr_q <= 1'b1;
					baddr_q <= '0;
					bdata_q <= code1;
					st_q <= S_CMD1;
				end
			end
			S_CMD1: begin
				if (cyc_done) begin
					start_q <= 1'b1;
					baddr_q <= addr_q;
					// read op: this cycle is the array read
					bwr_q <= (op_q != flash_host_pkg::OP_READ);
					bdata_q <= code2;
					st_q <= S_CMD2;
				end
			end
			S_CMD2: begin
				if (cyc_done) begin
					rdata_q <= cyc_rdata;
					if (op_q == flash_host_pkg::OP_PROG ||
						op_q == flash_host_pkg::OP_ERASE) begin
						// only bus reads from here on: polling, then for erase a verify pass
						start_q <= 1'b1;
						bwr_q <= 1'b0;
						st_q <= S_POLL;
					end else begin
						st_q <= S_END;
					end
				end
			end
			S_POLL: begin
				if (cyc_done) begin
					start_q <= 1'b1;
					if (polled_ok) begin
						st_q <= S_RECHK;
					end else if (cyc_rdata[flash_host_pkg::LIMIT_BIT]) begin
						st_q <= S_RECHK;
					end
				end
			end
			S_RECHK: begin
				if (cyc_done) begin
					// fresh read after status settles
					rdata_q <= cyc_rdata;
					if (!polled_ok) begin
						fail_q <= 1'b1;
						st_q <= S_END;
					end else if (op_q == flash_host_pkg::OP_ERASE) begin
						vaddr_q <= '0;
						start_q <= 1'b1;
						baddr_q <= '0;
						st_q <= S_VERIFY;
					end else begin
						vfail_q <= (cyc_rdata != data_q);
						st_q <= S_END;
					end
				end
			end
			S_VERIFY: begin
				if (cyc_done) begin
					if (cyc_rdata != flash_host_pkg::ERASED_BYTE)
						vfail_q <= 1'b1;
					if (vaddr_q == '1) begin
						st_q <= S_END;
					end else begin
						vaddr_q <= vaddr_q + 1'b1;
						baddr_q <= vaddr_q + 1'b1;
						start_q <= 1'b1;
					end
				end
			end
			default: begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
				O_VPP_EN <= 1'b0;
				st_q <= S_IDLE;
			end
			endcase
		end
	end
	// the pin cycle engine; toggle bit left to software via read data
	flash_bus_cycle #(.AW(AW), .PHASE(flash_host_pkg::PHASE_CYC)) u_cyc (
		.i_clk(I_MCLK),
		.i_rst(I_RST),
		.i_start(start_q),
		.i_write(bwr_q),
		.i_addr(baddr_q),
		.i_wdata(bdata_q),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_ce_n(O_CE_N),
		.o_we_n(O_WE_N),
		.o_oe_n(O_OE_N),
		.o_a(O_A),
		.o_dq_o(O_DQ_O),
		.o_dq_oe(O_DQ_OE),
		.i_dq_i(I_DQ_I)
	);
endmodule
`default_nettype wire

// ===== dv/flash_host_checker.sv
// checker: flash pin discipline of the host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_checker #(
	parameter int AW = 18
) (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_RD,
	input wire logic [31:0] O_RDATA,
	input wire logic O_CE_N,
	input wire logic O_WE_N,
	input wire logic O_OE_N,
	input wire logic [AW-1:0] O_A,
	input wire logic [7:0] O_DQ_O,
	input wire logic O_DQ_OE,
	input wire logic O_VPP_EN
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// a write strobe stays low, selected, with reads off
	sequence s_write_low;
		(!O_WE_N && !O_CE_N && O_OE_N)[*8];
	endsequence
	// supply settles before the write strobe falls
	sequence s_ramp;
		O_WE_N[*8];
	endsequence
	chk_write_pulse: assert property ($fell(O_WE_N) |-> s_write_low)
		else $error("write strobe pulse broken");
	chk_supply_ramp: assert property ($rose(O_VPP_EN) |-> s_ramp)
		else $error("write before supply ramp");
	chk_supply_write: assert property (!O_WE_N |-> O_VPP_EN)
		else $error("write without supply");
	chk_data_drive: assert property (!O_WE_N |-> O_DQ_OE)
		else $error("write data not driven");
	chk_read_free: assert property (!O_OE_N |-> !O_DQ_OE && !O_CE_N)
		else $error("read with bus driven");
	chk_addr_hold: assert property (!O_WE_N && !$past(O_WE_N) |->
		$stable(O_A) && $stable(O_DQ_O)) else $error("address moved");
	chk_read_answer: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
		else $error("read data outside its cycle");
	chk_supply_off: assert property ($fell(O_VPP_EN) |-> O_WE_N)
		else $error("supply dropped mid write");
endmodule
bind flash_host flash_host_checker #(.AW(AW)) u_chk (.I_MCLK(I_MCLK),
	.I_RST(I_RST), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_CE_N(O_CE_N),
	.O_WE_N(O_WE_N), .O_OE_N(O_OE_N), .O_A(O_A), .O_DQ_O(O_DQ_O),
	.O_DQ_OE(O_DQ_OE), .O_VPP_EN(O_VPP_EN));
`default_nettype wire

// ===== dv/flash_dev_model.sv
// behavioural flash device seen from its pins
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
	parameter int AW = 3
) (
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [AW-1:0] i_a,
	input wire logic [7:0] i_dq,
	input wire logic [3:0] i_busy_reads,
	input wire logic i_fail,
	output logic [7:0] o_dq
);
	logic [7:0] mem [2**AW];
	logic [7:0] pd = 8'h00, last = 8'h00;
	logic [AW-1:0] la = '0;
	logic [1:0] st = 2'h0;
	logic erasing = 0, prog = 0, tog = 0, armed = 0;
	int left = 0;
	initial foreach (mem[i]) mem[i] = 8'hff;
	// address taken when the later strobe falls; a write needs reads off
	always @(negedge i_we_n or negedge i_ce_n)
		if (!i_we_n && !i_ce_n) begin
			la = i_a;
			armed = i_oe_n;
		end
	// strobes may rise together, so act on whichever rises first
	always @(posedge i_we_n or posedge i_ce_n) if (armed) begin
		armed = 1'b0;
		if (erasing || prog) begin
			if (i_dq == 8'h00 || i_dq == 8'hff) {erasing, prog} = 2'b00;
		end else if (st == 2'h2) begin
			mem[la] = mem[la] & i_dq;
			pd = i_dq;
			prog = 1;
			st = 2'h0;
			left = int'(i_busy_reads);
		end else if (st == 2'h1 && i_dq == 8'h30) begin
			foreach (mem[i]) mem[i] = 8'h00;
			erasing = 1;
			st = 2'h0;
			left = int'(i_busy_reads);
		end else if (i_dq == 8'h30) st = 2'h1;
		else st = (i_dq == 8'h10 || i_dq == 8'h50) ? 2'h2 : 2'h0;
	end
	// each read advances the internal work; a failed run ends only on a 00 or ff write
	always @(negedge i_oe_n or negedge i_ce_n) if (!i_oe_n && !i_ce_n) begin
		tog = ~tog;
		if (erasing && left == 0 && !i_fail) begin
			foreach (mem[i]) mem[i] = 8'hff;
			erasing = 0;
		end
		if (prog && left == 0 && !i_fail) prog = 0;
		if (erasing) last = {1'b0, tog, i_fail, 5'h00};
		else if (prog) last = {~pd[7], tog, i_fail, mem[i_a][4:0]};
		else last = mem[i_a];
		if (left > 0) left--;
	end
	// released bus shows the inverse, never a held value
	assign o_dq = (!i_oe_n && !i_ce_n) ? last : ~last;
endmodule
`default_nettype wire

// ===== dv/flash_host_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_test;
	localparam int AW = 3;
	logic I_MCLK = 0, I_RST = 1, I_WR = 0, I_RD = 0, rd_q = 0, fl = 0;
	logic [3:0] I_ADDR = 4'h0, slow = 4'h0;
	logic [31:0] I_WDATA = 32'h0;
	wire logic [31:0] O_RDATA;
	wire logic O_CE_N, O_WE_N, O_OE_N, O_DQ_OE, O_VPP_EN;
	wire logic [AW-1:0] O_A;
	wire logic [7:0] O_DQ_O, dev_dq, I_DQ_I;
	logic [63:0] notes[$];
	logic [63:0] nt;
	logic [7:0] d;
	logic [AW-1:0] a;
	int fail_count = 0, n_checks = 0;
	always #2.5 I_MCLK = ~I_MCLK;
	assign I_DQ_I = O_DQ_OE ? O_DQ_O : dev_dq;
	flash_host #(.AW(AW), .SUPPLY_WAIT(4)) u_dut (.I_MCLK(I_MCLK),
		.I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
		.I_RD(I_RD), .O_RDATA(O_RDATA), .O_CE_N(O_CE_N), .O_WE_N(O_WE_N),
		.O_OE_N(O_OE_N), .O_A(O_A), .O_DQ_O(O_DQ_O), .O_DQ_OE(O_DQ_OE),
		.I_DQ_I(I_DQ_I), .O_VPP_EN(O_VPP_EN));
	flash_dev_model #(.AW(AW)) u_dev (.i_ce_n(O_CE_N), .i_we_n(O_WE_N),
		.i_oe_n(O_OE_N), .i_a(O_A), .i_dq(O_DQ_O), .i_busy_reads(slow),
		.i_fail(fl), .o_dq(dev_dq));
	// one register cycle; reads leave a masked note, zero mask unchecked
	task automatic bus(input logic w, input logic [3:0] ad,
		input logic [31:0] v, input logic [31:0] m, input logic [31:0] e);
		I_WR <= w;
		I_RD <= !w;
		I_ADDR <= ad;
		I_WDATA <= v;
		if (!w) notes.push_back({m, e});
		@(posedge I_MCLK);
	endtask
	task automatic idle;
		I_WR <= 1'b0;
		I_RD <= 1'b0;
		@(posedge I_MCLK);
	endtask
	// start an operation and poll busy under a bounded count
	task automatic op(input logic [1:0] code);
		logic busy;
		busy = 1'b1;
		slow <= 4'($urandom);
		bus(1, flash_host_pkg::REG_CTRL, {29'h0, code, 1'b1}, 0, 0);
		for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
			idle();
			repeat (40) @(posedge I_MCLK);
			bus(0, flash_host_pkg::REG_STAT, 0, 0, 0);
			// busy taken mid-cycle while the answer stands
			I_RD <= 1'b0;
			@(negedge I_MCLK) busy = O_RDATA[flash_host_pkg::ST_BUSY];
			@(posedge I_MCLK);
		end
		// a poll budget that runs out is a failure of its own
		if (busy !== 1'b0) begin
			fail_count++;
			$display("Error busy expected 0 seen %b", busy);
		end
	endtask
	// compare each answered read with the oldest note
	always @(posedge I_MCLK) begin
		if (rd_q && notes.size() > 0) begin
			nt = notes.pop_front();
			if (nt[63:32] !== 32'h0) begin
				n_checks++;
				if ((O_RDATA & nt[63:32]) !== nt[31:0]) begin
					fail_count++;
					$display("Error rdata expected %h seen %h", nt[31:0], O_RDATA);
				end
			end
		end
		rd_q <= I_RD;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		fail_count++;
		$display("Error run expected end seen timeout");
		stop_test();
	end
	initial begin
		void'($urandom(32'h0ed86e4e));
		repeat (12) @(posedge I_MCLK);
		I_RST <= 1'b0;
		@(posedge I_MCLK);
		// reset status and an unmapped place both read zero
		bus(0, flash_host_pkg::REG_STAT, 0, 32'hf, 0);
		bus(0, 4'hf, 0, 32'hffffffff, 0);
		a = AW'($urandom);
		d = 8'($urandom);
		bus(1, flash_host_pkg::REG_ADDR, 32'(a), 0, 0);
		bus(1, flash_host_pkg::REG_DATA, 32'(d), 0, 0);
		op(flash_host_pkg::OP_PROG);
		bus(0, flash_host_pkg::REG_STAT, 0, 32'hf, 32'h2);
		op(flash_host_pkg::OP_READ);
		bus(0, flash_host_pkg::REG_RDATA, 0, 32'hff, 32'(d));
		op(flash_host_pkg::OP_RESET);
		bus(0, flash_host_pkg::REG_STAT, 0, 32'hf, 32'h2);
		$display("program and reset test done");
		op(flash_host_pkg::OP_ERASE);
		bus(0, flash_host_pkg::REG_STAT, 0, 32'hf, 32'h2);
		op(flash_host_pkg::OP_READ);
		bus(0, flash_host_pkg::REG_RDATA, 0, 32'hff, 32'hff);
		bus(1, flash_host_pkg::REG_STAT, 0, 0, 0);
		bus(0, flash_host_pkg::REG_STAT, 0, 32'h2, 32'h0);
		$display("erase test done");
		// a run past its time limit must end as a failure
		fl <= 1'b1;
		op(flash_host_pkg::OP_PROG);
		bus(0, flash_host_pkg::REG_STAT, 0, 32'h7, 32'h6);
		idle();
		$display("time limit test done");
		repeat (4) @(posedge I_MCLK);
		stop_test();
	end
endmodule
`default_nettype wire
